//--- core/dcsp_pkg.sv
// Package with port addresses, field positions and timing constants of the disk port bank.
package dcsp_pkg;

    // ------------------------------------------------------------------
    // Port addresses
    // ------------------------------------------------------------------
    localparam logic [9:0] PRI_FLOPPY_OUTPUT = 10'h3F2;
    localparam logic [9:0] PRI_FLOPPY_STATUS = 10'h3F4;
    localparam logic [9:0] PRI_FIXED_PORT    = 10'h3F6;
    localparam logic [9:0] PRI_LINE_PORT     = 10'h3F7;
    localparam logic [9:0] SEC_OFFSET_DELTA  = 10'h080;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int FOC_MOTOR_SECOND = 5;
    localparam int FOC_MOTOR_FIRST  = 4;
    localparam int FOC_REQ_GATE     = 3;
    localparam int FOC_RESET_N      = 2;
    localparam int FOC_UNIT_PICK    = 0;
    localparam int FDC_HEAD3_EN     = 3;
    localparam int FDC_RESET        = 2;
    localparam int FDC_INT_MASK_N   = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] FOC_RESET_VAL  = 8'h00;
    localparam logic [7:0] FDC_RESET_VAL  = 8'h02;
    localparam logic [1:0] RATE_RESET_VAL = 2'h0;

    // ------------------------------------------------------------------
    // Rate codes
    // ------------------------------------------------------------------
    localparam logic [1:0] RATE_500_MFM = 2'h0;
    localparam logic [1:0] RATE_300_MFM = 2'h1;
    localparam logic [1:0] RATE_250_MFM = 2'h2;
    localparam logic [1:0] RATE_125_FM  = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS        = 10000;
    localparam int FLOPPY_RESET_TIME_PS = 3500000;
    localparam int FLOPPY_RESET_CYCLES  =
        (FLOPPY_RESET_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1 ? 1 :
        (FLOPPY_RESET_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

//--- core/dcsp_ports.sv
// Host-visible control and status port bank of the disk controller board.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Motor bits off turn drive off, block select
// - Request gate bit passes floppy DMA, interrupt
// - Reset bit zero holds floppy controller reset
// - Unit pick zero selects A, one B
// - Status bit 7 shows transfer ready
// - Status bit 6 shows transfer direction
// - Status bit 5 shows non-DMA execution phase
// - Bit 4 command active, bits 3,2 zero
// - Bits 1,0 show drive B, A seeking
// - Mirror port returns fixed-disk status bits
// - Corrected bit set by local microcontroller
// - Index bit follows selected drive index
// - Error bit set by local microcontroller
// - Control bit 3 enables fourth head line
// - Rate code selects floppy rate, reset 500
// - Control bit 2 holds fixed-disk reset
// - Mask bit gates interrupt, reset leaves masked
module dcsp_ports #(
    parameter bit SECONDARY = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [9:0] ioAddr,
    input  wire logic       ioRd,
    input  wire logic       ioWr,
    input  wire logic [7:0] ioWdata,
    output logic      [7:0] ioRdata,
    output logic            ioRdataOe,
    input  wire logic       transferReady,
    input  wire logic       transferDirection,
    input  wire logic       executionPhase,
    input  wire logic       commandActive,
    input  wire logic [1:0] unitSeeking,
    input  wire logic       floppyDmaReq,
    input  wire logic       floppyIrqReq,
    input  wire logic       controllerBusy,
    input  wire logic       driveReady,
    input  wire logic       writeFault,
    input  wire logic       seekComplete,
    input  wire logic       dataRequest,
    input  wire logic       dataCorrected,
    input  wire logic       indexPulse,
    input  wire logic       errorFlag,
    input  wire logic       fixedIrqReq,
    input  wire logic       mediaChanged,
    input  wire logic       writeGateLine,
    input  wire logic [3:0] headLines,
    input  wire logic [1:0] unitLines,
    output logic            motorOnFirst,
    output logic            motorOnSecond,
    output logic [1:0]      floppyUnitSel,
    output logic            floppyReset,
    output logic            floppyDmaOut,
    output logic            floppyIrqOut,
    output logic            headLine3Enable,
    output logic            fixedReset,
    output logic            fixedIrqOut,
    output logic [1:0]      rateCode
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // A zero count would let a reset write pass without any hold time.
    if (dcsp_pkg::FLOPPY_RESET_CYCLES < 1) begin : g_bad
        $error("Floppy reset count must be at least one cycle.");
    end

    localparam logic [9:0] BASE_DELTA = SECONDARY ? dcsp_pkg::SEC_OFFSET_DELTA : 10'h000;
    localparam int         RCW        = $clog2(dcsp_pkg::FLOPPY_RESET_CYCLES + 1);
    localparam logic [RCW-1:0] RST_CNT =
        RCW'(dcsp_pkg::FLOPPY_RESET_CYCLES);

    // Compares against the primary address moved down by the bank offset.
    function automatic logic hit(input logic [9:0] a, input logic [9:0] port);
        hit = (a == port - BASE_DELTA);
    endfunction

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // The secondary bank sits below the primary one; one subtraction in the
    // compare keeps a single decode for both banks.
    wire logic selOut    = hit(ioAddr, dcsp_pkg::PRI_FLOPPY_OUTPUT);
    wire logic selStatus = hit(ioAddr, dcsp_pkg::PRI_FLOPPY_STATUS);
    wire logic selFixed  = hit(ioAddr, dcsp_pkg::PRI_FIXED_PORT);
    wire logic selLine   = hit(ioAddr, dcsp_pkg::PRI_LINE_PORT);
    wire logic wrOut     = ioWr & selOut;
    wire logic wrFixed   = ioWr & selFixed;
    wire logic wrRate    = ioWr & selLine;
    wire logic rdAny     = ioRd & (selStatus | selFixed | selLine);
    // Reserved bits are dropped on the way in, so they can never reach an output.
    wire logic [7:0] outCtlWr = ioWdata & 8'h3D;
    wire logic [7:0] fixCtlWr = ioWdata & 8'h0E;
    wire logic [1:0] rateWr   = ioWdata[1:0];

    // ------------------------------------------------------------------
    // Written registers
    // ------------------------------------------------------------------
    logic [7:0]     outCtl_ff;
    logic [7:0]     fixCtl_ff;
    logic [1:0]     rate_ff;
    logic [RCW-1:0] fRstCnt_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            outCtl_ff <= dcsp_pkg::FOC_RESET_VAL;
        end else if (wrOut) begin
            outCtl_ff <= outCtlWr;
        end
    end

    // The mask bit comes out of reset set, so a master reset leaves the
    // fixed-disk interrupt masked until software clears it.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fixCtl_ff <= dcsp_pkg::FDC_RESET_VAL;
        end else if (wrFixed) begin
            fixCtl_ff <= fixCtlWr;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rate_ff <= dcsp_pkg::RATE_RESET_VAL;
        end else if (wrRate) begin
            rate_ff <= rateWr;
        end
    end

    // ------------------------------------------------------------------
    // Floppy reset stretch
    // ------------------------------------------------------------------
    // A write of 0 to the reset bit stretches reset to the minimum time,
    // even if software sets the bit again immediately.
    wire logic fRstReq = wrOut & ~ioWdata[dcsp_pkg::FOC_RESET_N];
    wire logic [RCW-1:0] nxt_fRstCnt = fRstReq ? RST_CNT :
        (fRstCnt_ff != '0) ? RCW'(fRstCnt_ff - 1'b1) : fRstCnt_ff;

    // The counter idles after master reset: the stored reset bit is already 0
    // there, which keeps the floppy controller in reset on its own.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fRstCnt_ff <= '0;
        end else begin
            fRstCnt_ff <= nxt_fRstCnt;
        end
    end

    // ------------------------------------------------------------------
    // Drive-side outputs
    // ------------------------------------------------------------------
    wire logic mFirst  = outCtl_ff[dcsp_pkg::FOC_MOTOR_FIRST];
    wire logic mSecond = outCtl_ff[dcsp_pkg::FOC_MOTOR_SECOND];
    wire logic pickB   = outCtl_ff[dcsp_pkg::FOC_UNIT_PICK];
    wire logic gateReq = outCtl_ff[dcsp_pkg::FOC_REQ_GATE];
    // Selection needs the matching motor bit, so a drive is never picked while its motor is off.
    wire logic [1:0] nxt_unitSel = {pickB & mSecond, ~pickB & mFirst};
    wire logic nxt_fReset = (fRstCnt_ff != '0) | ~outCtl_ff[dcsp_pkg::FOC_RESET_N];
    // With the gate closed the request outputs sit low, standing in for
    // request drivers that are switched off.
    wire logic nxt_dmaOut = floppyDmaReq & gateReq;
    wire logic nxt_irqOut = floppyIrqReq & gateReq;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            motorOnFirst <= 1'b0;
        end else begin
            motorOnFirst <= mFirst;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            motorOnSecond <= 1'b0;
        end else begin
            motorOnSecond <= mSecond;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            floppyUnitSel <= 2'h0;
        end else begin
            floppyUnitSel <= nxt_unitSel;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            floppyReset <= 1'b1;
        end else begin
            floppyReset <= nxt_fReset;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            floppyDmaOut <= 1'b0;
        end else begin
            floppyDmaOut <= nxt_dmaOut;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            floppyIrqOut <= 1'b0;
        end else begin
            floppyIrqOut <= nxt_irqOut;
        end
    end

    // ------------------------------------------------------------------
    // Fixed-disk outputs
    // ------------------------------------------------------------------
    // A masked copy rather than a latch: the controller keeps the request
    // level, so a pending interrupt shows again once the mask is cleared.
    wire logic nxt_fIrq = fixedIrqReq & ~fixCtl_ff[dcsp_pkg::FDC_INT_MASK_N];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            headLine3Enable <= 1'b0;
        end else begin
            headLine3Enable <= fixCtl_ff[dcsp_pkg::FDC_HEAD3_EN];
        end
    end

    // The fixed-disk reset is a plain copy of the stored bit; holding it
    // long enough is left to the host.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fixedReset <= 1'b0;
        end else begin
            fixedReset <= fixCtl_ff[dcsp_pkg::FDC_RESET];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fixedIrqOut <= 1'b0;
        end else begin
            fixedIrqOut <= nxt_fIrq;
        end
    end

    // ------------------------------------------------------------------
    // Rate output
    // ------------------------------------------------------------------
    // Only the two low bits are stored; the rest of the written byte is ignored.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rateCode <= dcsp_pkg::RATE_RESET_VAL;
        end else begin
            rateCode <= rate_ff;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Status words are built from live inputs; nothing is latched, so a read
    // shows the levels present at its sampling edge.
    wire logic [7:0] floppyStatus = {transferReady, transferDirection,
        executionPhase, commandActive, 2'b00, unitSeeking};
    wire logic [7:0] fixedStatus  = {controllerBusy, driveReady, writeFault,
        seekComplete, dataRequest, dataCorrected, indexPulse, errorFlag};
    wire logic [7:0] lineStatus   = {mediaChanged, writeGateLine,
        headLines, unitLines};
    // Write-only ports never drive the data bus.
    wire logic [7:0] nxt_rdata = selStatus ? floppyStatus :
        selFixed ? fixedStatus : selLine ? lineStatus : 8'h00;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ioRdata <= 8'h00;
        end else begin
            ioRdata <= rdAny ? nxt_rdata : 8'h00;
        end
    end

    // The enable is registered like the data, so both change on the same edge.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ioRdataOe <= 1'b0;
        end else begin
            ioRdataOe <= rdAny;
        end
    end

endmodule

`default_nettype wire

//--- sim/dcsp_ports_asserts.sv
// Concurrent checks on the ports of the disk port bank.
`timescale 1ns/100ps
`default_nettype none
module dcsp_ports_asserts #(parameter bit SECONDARY = 1'b0) (
    input wire logic       clk, nrst, ioRd, ioWr, ioRdataOe, fixedIrqReq,
    input wire logic       motorOnFirst, motorOnSecond, floppyReset, fixedIrqOut,
    input wire logic [9:0] ioAddr,
    input wire logic [7:0] ioWdata, ioRdata,
    input wire logic [1:0] floppyUnitSel, rateCode
);
    // Folding the secondary block onto the primary map keeps one set of checks.
    wire logic [9:0] adr = ioAddr + (SECONDARY ? 10'h080 : 10'h000);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_status_zeros: assert property (
        ioRd && adr == 10'h3F4 |=> ioRdataOe && ioRdata[3:2] == 2'h0) else $error("bad bits");
    a_wo_quiet: assert property (
        ioRd && adr == 10'h3F2 |=> !ioRdataOe && ioRdata == 8'h00) else $error("wo read");
    a_mirror_read: assert property (
        ioRd && adr == 10'h3F6 |=> ioRdataOe) else $error("mirror read");
    a_readback_read: assert property (
        ioRd && adr == 10'h3F7 |=> ioRdataOe) else $error("readback read");
    a_rate_write: assert property (
        ioWr && adr == 10'h3F7 |-> ##2 rateCode == $past(ioWdata[1:0], 2)) else $error("rate");
    a_sel_motor: assert property (
        (floppyUnitSel & ~{motorOnSecond, motorOnFirst}) == 2'h0) else $error("sel no motor");
    a_irq_mask: assert property (
        fixedIrqOut |-> $past(fixedIrqReq)) else $error("irq no request");
    a_reset_hold: assert property (
        $rose(nrst) |-> floppyReset && !fixedIrqOut && rateCode == 2'h0) else $error("reset");
endmodule
`default_nettype wire

//--- sim/dcsp_host.sv
// Host bus model that issues byte writes and reads to the port bank.
`timescale 1ns/100ps
`default_nettype none
module dcsp_host (
    input  wire logic       clk, ioRdataOe,
    input  wire logic [7:0] ioRdata,
    output logic            ioRd, ioWr,
    output logic      [9:0] ioAddr,
    output logic      [7:0] ioWdata
);
    initial {ioAddr, ioRd, ioWr, ioWdata} = '0;
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge clk);
        ioAddr  <= a;
        ioWdata <= v;
        ioWr    <= 1'b1;
        @(posedge clk);
        ioWr    <= 1'b0;
        // A released data bus must not keep showing the written byte.
        ioWdata <= ~v;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] v, output logic oe);
        @(posedge clk);
        ioAddr <= a;
        ioRd   <= 1'b1;
        @(posedge clk);
        ioRd <= 1'b0;
        #1;
        v  = ioRdata;
        oe = ioRdataOe;
    endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the disk port bank.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       clk = 1'b0, nrst, ioRd, ioWr, ioRdataOe, floppyDmaReq, floppyIrqReq;
    logic       transferReady, transferDirection, executionPhase, commandActive;
    logic       controllerBusy, driveReady, writeFault, seekComplete, dataRequest;
    logic       dataCorrected, indexPulse, errorFlag, fixedIrqReq, mediaChanged;
    logic       writeGateLine, motorOnFirst, motorOnSecond, floppyReset, floppyDmaOut;
    logic       floppyIrqOut, headLine3Enable, fixedReset, fixedIrqOut;
    logic [9:0] ioAddr;
    logic [7:0] ioWdata, ioRdata;
    logic [3:0] headLines;
    logic [1:0] unitSeeking, unitLines, floppyUnitSel, rateCode;
    int         error_cnt = 0, check_count = 0, cyc = 0;
    wire logic [11:0] outs = {floppyReset, floppyDmaOut, floppyIrqOut, floppyUnitSel,
        motorOnSecond, motorOnFirst, headLine3Enable, fixedReset, fixedIrqOut, rateCode};
    dcsp_ports u_dut (
        .clk(clk), .nrst(nrst), .ioAddr(ioAddr), .ioRd(ioRd), .ioWr(ioWr),
        .ioWdata(ioWdata), .ioRdata(ioRdata), .ioRdataOe(ioRdataOe),
        .transferReady(transferReady), .transferDirection(transferDirection),
        .executionPhase(executionPhase), .commandActive(commandActive),
        .unitSeeking(unitSeeking), .floppyDmaReq(floppyDmaReq),
        .floppyIrqReq(floppyIrqReq), .controllerBusy(controllerBusy),
        .driveReady(driveReady), .writeFault(writeFault), .seekComplete(seekComplete),
        .dataRequest(dataRequest), .dataCorrected(dataCorrected),
        .indexPulse(indexPulse), .errorFlag(errorFlag), .fixedIrqReq(fixedIrqReq),
        .mediaChanged(mediaChanged), .writeGateLine(writeGateLine),
        .headLines(headLines), .unitLines(unitLines), .motorOnFirst(motorOnFirst),
        .motorOnSecond(motorOnSecond), .floppyUnitSel(floppyUnitSel),
        .floppyReset(floppyReset), .floppyDmaOut(floppyDmaOut),
        .floppyIrqOut(floppyIrqOut), .headLine3Enable(headLine3Enable),
        .fixedReset(fixedReset), .fixedIrqOut(fixedIrqOut), .rateCode(rateCode)
    );
    dcsp_host  u_host (
        .clk(clk), .ioRdataOe(ioRdataOe), .ioRdata(ioRdata), .ioRd(ioRd),
        .ioWr(ioWr), .ioAddr(ioAddr), .ioWdata(ioWdata)
    );
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_writes();
        logic [29:0] w [11] = '{{10'h3F2, 8'h1C, 12'h6A0}, {10'h3F2, 8'hED, 12'h740},
            {10'h3F2, 8'h11, 12'h820}, {10'h3F2, 8'h33, 12'h960}, {10'h3F6, 8'hFC, 12'h97C},
            {10'h3F6, 8'h02, 12'h960}, {10'h3F6, 8'h00, 12'h964}, {10'h3F7, 8'h01, 12'h965},
            {10'h3F7, 8'h02, 12'h966}, {10'h3F7, 8'h03, 12'h967}, {10'h3F4, 8'hFF, 12'h967}};
        foreach (w[i]) begin
            u_host.wr(w[i][29:20], w[i][19:12]);
            repeat (2) @(posedge clk);
            #1;
            chk(outs, w[i][11:0]);
            if (w[i][29:20] == 10'h3F6 && w[i][14]) repeat (500) @(posedge clk);
        end
    endtask
    task automatic t_reads();
        logic [18:0] r [5] = '{{10'h3F4, 9'h1A1}, {10'h3F6, 9'h196}, {10'h3F7, 9'h1C5},
            {10'h3F2, 9'h000}, {10'h3F5, 9'h000}};
        logic [7:0]  v;
        logic        oe;
        @(posedge clk);
        {transferReady, transferDirection, executionPhase, commandActive, unitSeeking} <= 6'h29;
        {controllerBusy, driveReady, writeFault, seekComplete} <= 4'h9;
        {dataRequest, dataCorrected, indexPulse, errorFlag} <= 4'h6;
        {mediaChanged, writeGateLine, headLines, unitLines} <= 8'hC5;
        foreach (r[i]) begin
            u_host.rd(r[i][18:9], v, oe);
            chk({3'h0, oe, v}, {3'h0, r[i][8:0]});
        end
    endtask
    task automatic t_floppy_reset_n();
        u_host.wr(10'h3F2, 8'h18);
        u_host.wr(10'h3F2, 8'h1C);
        repeat (2) @(posedge clk);
        #1;
        chk(outs, 12'hEA7);
        @(posedge clk);
        floppyDmaReq <= 1'b0;
        repeat (350) @(posedge clk);
        #1;
        chk(outs, 12'h2A7);
    endtask
    initial begin
        nrst = 1'b0;
        {transferReady, transferDirection, executionPhase, commandActive, unitSeeking} = '0;
        {controllerBusy, driveReady, writeFault, seekComplete, dataRequest} = '0;
        {dataCorrected, indexPulse, errorFlag, mediaChanged, writeGateLine} = '0;
        {headLines, unitLines} = '0;
        {floppyDmaReq, floppyIrqReq, fixedIrqReq} = 3'h7;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(outs, 12'h800);
        t_writes();
        t_reads();
        t_floppy_reset_n();
        end_of_test();
    end
endmodule
bind dcsp_ports dcsp_ports_asserts #(.SECONDARY(SECONDARY)) u_chk (
    .clk(clk), .nrst(nrst), .ioRd(ioRd), .ioWr(ioWr), .ioRdataOe(ioRdataOe),
    .fixedIrqReq(fixedIrqReq), .motorOnFirst(motorOnFirst), .motorOnSecond(motorOnSecond),
    .floppyReset(floppyReset), .fixedIrqOut(fixedIrqOut), .ioAddr(ioAddr),
    .ioWdata(ioWdata), .ioRdata(ioRdata), .floppyUnitSel(floppyUnitSel),
    .rateCode(rateCode)
);
`default_nettype wire
